// File: hw/dbgbk_defs.vh
`ifndef DBGBK_DEFS_VH
`define DBGBK_DEFS_VH
// Status/control bit positions
`define DBGBK_PERMIT_BIT    7
`define DBGBK_ACTIVE_BIT    6
`define DBGBK_BKEN_BIT      5
`define DBGBK_TYPE_BIT      4
`define DBGBK_CLKSEL_BIT    3
`define DBGBK_WS_BIT        2
`define DBGBK_WSF_BIT       1
`define DBGBK_DVF_BIT       0
// Serial command codes
`define DBGBK_CMD_BACKGROUND 8'h90
`define DBGBK_CMD_READ_STAT  8'he4
`define DBGBK_CMD_WRITE_CTL  8'hc4
`define DBGBK_CMD_MATCH_RD   8'he2
`define DBGBK_CMD_MATCH_WR   8'hc2
`define DBGBK_CMD_GO         8'h08
// Reset values
`define DBGBK_CTL_RESET      8'h00
`define DBGBK_MATCH_RESET    16'hffff
`endif

// File: hw/dbgbk_addr_match.v
`timescale 1ns/10ps
// Address comparator with combinational hit
module dbgbk_addr_match #(
  parameter AW = 16
) (
  input  wire          clk,        // System clock
  input  wire          sys_rst,    // Synchronous reset
  input  wire [AW-1:0] cpuAddr,    // CPU address bus
  input  wire          cpuAccess,  // Access strobe this cycle
  input  wire [AW-1:0] matchAddr,  // Breakpoint match value
  output wire          hitNow      // Combinational hit
);
  // Compare on every access; no sampling delay so the tag meets its fetch
  assign hitNow = cpuAccess && (cpuAddr == matchAddr);
endmodule // dbgbk_addr_match

// File: hw/dbgbk_cmd_decode.v
`timescale 1ns/10ps
`include "dbgbk_defs.vh"
// Command byte decoder; one-hot strobes qualified by cmdValid
module dbgbk_cmd_decode (
  input  wire [7:0] cmdCode,    // Command code
  input  wire       cmdValid,   // Command strobe
  output wire       isBackgnd,  // Background request
  output wire       isRdStat,   // Status read
  output wire       isWrCtl,    // Control write
  output wire       isMatchRd,  // Match read
  output wire       isMatchWr,  // Match write
  output wire       isGo        // Resume user program
);
  // Plain equality decode
  assign isBackgnd = cmdValid && (cmdCode == `DBGBK_CMD_BACKGROUND);
  assign isRdStat  = cmdValid && (cmdCode == `DBGBK_CMD_READ_STAT);
  assign isWrCtl   = cmdValid && (cmdCode == `DBGBK_CMD_WRITE_CTL);
  assign isMatchRd = cmdValid && (cmdCode == `DBGBK_CMD_MATCH_RD);
  assign isMatchWr = cmdValid && (cmdCode == `DBGBK_CMD_MATCH_WR);
  assign isGo      = cmdValid && (cmdCode == `DBGBK_CMD_GO);
endmodule // dbgbk_cmd_decode

// File: hw/dbgbk_top.v
// Summary of operation
// - Every CPU address is compared with the 16-bit match register.
// - Forced type: any access to match address enters background at next boundary.
// - Tagged type: match tags opcode; background only if it reaches queue end.
// - Breakpoint enable bit 5 resets low; when low no breakpoint is requested.
// - Type select bit 4: one forced, zero tagged.
// - Registers reachable only by serial commands, never by user program.
// - Permit bit 7 writes ignored while in active background mode.
// - Permit zero blocks background entry; normal reset clears it.
// - Four status bits are read-only; control writes never change them.
// - Active flag bit 6 is one in background mode, zero when running.
// - Clock select bit 3 resets zero, one selects bus clock, always writable.
// - Wait/stop bit 2 set in wait/stop or when background pulled CPU out.
// - Background command pulls CPU out of wait or stop.
// - Wait/stop failure bit 1 set when access command fails from wait/stop.
// - Data-valid failure bit 0 present but unused.
// - Background command 90 enters background only with permit set.
// - Command E4 returns the eight status bits.
// - Command C4 writes the control bits.
// - Command E2 reads match register sixteen bits; C2 writes it.
`timescale 1ns/10ps
`include "dbgbk_defs.vh"
module dbgbk_top #(
  parameter AW = 16
) (
  input  wire          clk,           // System clock
  input  wire          sys_rst,       // Synchronous reset, active high
  input  wire [7:0]    cmdCode,       // Decoded serial command byte
  input  wire          cmdValid,      // Command strobe, one cycle
  input  wire [15:0]   cmdWrData,     // Write data; control uses low byte
  output reg  [15:0]   cmdRdData,     // Read data for status or match
  output reg           cmdRdValid,    // Read data valid pulse
  input  wire [AW-1:0] cpuAddr,       // CPU address bus
  input  wire          cpuAccess,     // CPU bus access strobe
  input  wire          cpuOpFetch,    // Access is an opcode fetch
  input  wire          cpuInstrBound, // Instruction boundary pulse
  input  wire          cpuQueueEnd,   // Opcode at end of queue pulse
  input  wire          cpuWaitStop,   // CPU in wait or stop
  input  wire          memCmdFail,    // Access command hit wait/stop
  output wire          bkgndRequest,  // Enter background now
  output wire          tagExecBlock,  // Queue-end opcode is tagged
  output wire          commClockBus   // Comm clock select (1 bus clock)
);
  reg  [15:0] matchAddr_reg;          // Breakpoint match address
  reg         permit_reg;
  reg         active_reg;
  reg         bkEnable_reg;
  reg         typeForced_reg;
  reg         clkSel_reg;
  reg         wsFromBg_reg;
  reg         wsFail_reg;
  reg         forcePend_reg;
  reg         tagFlag_reg;            // Tag carried with fetched opcode
  wire        hitNow;
  wire        isBackgnd;
  wire        isRdStat;
  wire        isWrCtl;
  wire        isMatchRd;
  wire        isMatchWr;
  wire        isGo;
  wire        enterBg;
  wire [7:0]  statusByte;
  wire [7:0]  ctlReset = `DBGBK_CTL_RESET; // Named reset byte, sliced per bit

  dbgbk_addr_match #(.AW(AW)) uMatch (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .cpuAddr   (cpuAddr),
    .cpuAccess (cpuAccess),
    .matchAddr (matchAddr_reg[AW-1:0]),
    .hitNow    (hitNow)
  );

  // Only serial commands reach the registers; no CPU write path exists
  dbgbk_cmd_decode uDec (
    .cmdCode   (cmdCode),
    .cmdValid  (cmdValid),
    .isBackgnd (isBackgnd),
    .isRdStat  (isRdStat),
    .isWrCtl   (isWrCtl),
    .isMatchRd (isMatchRd),
    .isMatchWr (isMatchWr),
    .isGo      (isGo)
  );

  // Forced hit waits for the next instruction boundary
  always @(posedge clk) begin
    if (sys_rst) begin
      forcePend_reg <= 1'b0;
    end else if (active_reg) begin
      forcePend_reg <= 1'b0;
    end else if (bkEnable_reg && typeForced_reg && hitNow) begin
      forcePend_reg <= 1'b1;
    end else if (cpuInstrBound) begin
      forcePend_reg <= 1'b0;
    end
  end

  // Tag follows the opcode fetch; cleared at queue end or while active
  always @(posedge clk) begin
    if (sys_rst) begin
      tagFlag_reg <= 1'b0;
    end else if (cpuAccess && cpuOpFetch) begin
      tagFlag_reg <= bkEnable_reg && !typeForced_reg && hitNow;
    end else if (cpuQueueEnd || active_reg) begin
      tagFlag_reg <= 1'b0;
    end
  end

  // Breakpoint requests are only honoured when background is permitted
  assign tagExecBlock = permit_reg && tagFlag_reg && cpuQueueEnd;
  assign enterBg      = permit_reg && !active_reg &&
                        ((forcePend_reg && cpuInstrBound) || tagExecBlock ||
                         isBackgnd);
  assign bkgndRequest = enterBg;
  assign commClockBus = clkSel_reg;

  // Control bits; status bits are not in this write path
  always @(posedge clk) begin
    if (sys_rst) begin
      permit_reg     <= ctlReset[`DBGBK_PERMIT_BIT];
      bkEnable_reg   <= ctlReset[`DBGBK_BKEN_BIT];
      typeForced_reg <= ctlReset[`DBGBK_TYPE_BIT];
      clkSel_reg     <= ctlReset[`DBGBK_CLKSEL_BIT];
    end else if (isWrCtl) begin
      if (!active_reg) begin
        permit_reg <= cmdWrData[`DBGBK_PERMIT_BIT];
      end
      bkEnable_reg   <= cmdWrData[`DBGBK_BKEN_BIT];
      typeForced_reg <= cmdWrData[`DBGBK_TYPE_BIT];
      clkSel_reg     <= cmdWrData[`DBGBK_CLKSEL_BIT];
    end
  end

  // Match register written by its own command
  always @(posedge clk) begin
    if (sys_rst) begin
      matchAddr_reg <= `DBGBK_MATCH_RESET;
    end else if (isMatchWr) begin
      matchAddr_reg <= cmdWrData;
    end
  end

  // Active flag and wait/stop tracking
  always @(posedge clk) begin
    if (sys_rst) begin
      active_reg   <= 1'b0;
      wsFromBg_reg <= 1'b0;
    end else if (enterBg) begin
      active_reg   <= 1'b1;
      wsFromBg_reg <= cpuWaitStop;
    end else if (isGo && active_reg) begin
      active_reg   <= 1'b0;
      wsFromBg_reg <= 1'b0;
    end
  end

  // Failure flag sticks until next background entry (host recovery point)
  always @(posedge clk) begin
    if (sys_rst) begin
      wsFail_reg <= 1'b0;
    end else if (memCmdFail && cpuWaitStop) begin
      wsFail_reg <= 1'b1;
    end else if (enterBg) begin
      wsFail_reg <= 1'b0;
    end
  end

  // Status assembly; data-valid failure hardwired low
  assign statusByte = {permit_reg, active_reg, bkEnable_reg, typeForced_reg,
                       clkSel_reg, (cpuWaitStop && !active_reg) || wsFromBg_reg,
                       wsFail_reg, 1'b0};

  // Read answers registered one cycle after the command strobe
  always @(posedge clk) begin
    if (sys_rst) begin
      cmdRdData  <= 16'h0000;
      cmdRdValid <= 1'b0;
    end else begin
      cmdRdValid <= isRdStat || isMatchRd;
      if (isRdStat) begin
        cmdRdData <= {8'h00, statusByte};
      end else if (isMatchRd) begin
        cmdRdData <= matchAddr_reg;
      end
    end
  end
endmodule // dbgbk_top

// File: test/dbgbk_cpu_model.sv
`timescale 1ns/10ps
// CPU stand-in: boundary every 4 cycles, queue end 2 cycles after a fetch
module dbgbk_cpu_model (
  input  wire clk,        // System clock
  input  wire fetch,      // Opcode fetch this cycle
  output reg  instrBound, // Boundary pulse
  output reg  queueEnd    // Queue end pulse
);
  reg [2:0] cntReg  = 3'h0;
  reg [1:0] pipeReg = 2'h0;
  // Fetch is sampled on the rising edge to stay clear of bench drives
  always @(posedge clk) begin
    pipeReg <= {pipeReg[0], fetch};
  end
  // Outputs change at the falling edge like the bench
  always @(negedge clk) begin
    cntReg     <= cntReg + 3'h1;
    instrBound <= (cntReg[1:0] == 2'h3);
    queueEnd   <= pipeReg[1];
  end
endmodule // dbgbk_cpu_model

// File: test/dbgbk_top_properties.sv
`timescale 1ns/10ps
// Port-level checks of the breakpoint and status block
module dbgbk_top_properties #(
  parameter AW = 16
) (
  input wire        clk,           // Clock
  input wire        sys_rst,       // Sync reset
  input wire [7:0]  cmdCode,       // Command code
  input wire        cmdValid,      // Command strobe
  input wire [15:0] cmdWrData,     // Write data
  input wire [15:0] cmdRdData,     // Read data
  input wire        cmdRdValid,    // Read valid
  input wire        cpuInstrBound, // Boundary
  input wire        cpuQueueEnd,   // Queue end
  input wire        bkgndRequest,  // Request
  input wire        tagExecBlock,  // Tag block
  input wire        commClockBus   // Clock select
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Command recognisers
  wire rdCmd = cmdValid && (cmdCode == 8'he4 || cmdCode == 8'he2);
  sequence s_anyRd; rdCmd; endsequence
  sequence s_statRd; cmdValid && cmdCode == 8'he4; endsequence
  sequence s_ctlWr; cmdValid && cmdCode == 8'hc4; endsequence
  a_read_answer_next: assert property (s_anyRd |=> cmdRdValid)
    else $error("read not answered");
  a_no_stray_valid: assert property (cmdRdValid |-> $past(rdCmd))
    else $error("read valid without read");
  a_status_pad_zero: assert property (s_statRd |=> cmdRdData[15:8] == 8'h00 && !cmdRdData[0])
    else $error("status padding not zero");
  a_clksel_write: assert property (s_ctlWr |=> commClockBus == $past(cmdWrData[3]))
    else $error("clock select not written");
  a_clksel_hold: assert property (!(cmdValid && cmdCode == 8'hc4) |=> $stable(commClockBus))
    else $error("clock select changed");
  a_req_on_event: assert property (bkgndRequest |-> cpuInstrBound || cpuQueueEnd ||
    (cmdValid && cmdCode == 8'h90))
    else $error("request off boundary");
  a_tag_at_end: assert property (tagExecBlock |-> cpuQueueEnd && bkgndRequest)
    else $error("tag block off queue end");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !cmdRdValid && !commClockBus)
    else $error("outputs not cleared");
endmodule // dbgbk_top_properties

bind dbgbk_top dbgbk_top_properties #(.AW(AW)) u_dbgbk_top_properties (.clk(clk),
  .sys_rst(sys_rst), .cmdCode(cmdCode), .cmdValid(cmdValid), .cmdWrData(cmdWrData),
  .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cpuInstrBound(cpuInstrBound),
  .cpuQueueEnd(cpuQueueEnd), .bkgndRequest(bkgndRequest), .tagExecBlock(tagExecBlock),
  .commClockBus(commClockBus));

// File: test/tb_top.sv
`timescale 1ns/10ps
// Command and CPU bus driven bench
module tb_top;
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg  [7:0]  cmdCode = 8'h00;
  reg         cmdValid = 1'b0;
  reg  [15:0] cmdWrData = 16'h0000;
  reg  [15:0] cpuAddr = 16'h0000;
  reg         cpuAccess = 1'b0;
  reg         cpuOpFetch = 1'b0;
  reg         cpuWaitStop = 1'b0;
  reg         memCmdFail = 1'b0;
  wire [15:0] cmdRdData;
  wire        cmdRdValid, cpuInstrBound, cpuQueueEnd, bkgndRequest, tagExecBlock, commClockBus;
  integer     err_total = 0;
  integer     n_checks = 0;
  dbgbk_top u_dbgbk_top (.clk(clk), .sys_rst(sys_rst), .cmdCode(cmdCode), .cmdValid(cmdValid),
    .cmdWrData(cmdWrData), .cmdRdData(cmdRdData), .cmdRdValid(cmdRdValid), .cpuAddr(cpuAddr),
    .cpuAccess(cpuAccess), .cpuOpFetch(cpuOpFetch), .cpuInstrBound(cpuInstrBound),
    .cpuQueueEnd(cpuQueueEnd), .cpuWaitStop(cpuWaitStop), .memCmdFail(memCmdFail),
    .bkgndRequest(bkgndRequest), .tagExecBlock(tagExecBlock), .commClockBus(commClockBus));
  dbgbk_cpu_model u_dbgbk_cpu_model (.clk(clk), .fetch(cpuOpFetch),
    .instrBound(cpuInstrBound), .queueEnd(cpuQueueEnd));
  // 100 MHz clock
  initial forever #5 clk = ~clk;
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task check(input [15:0] got, input [15:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // One command strobe; a gap cycle follows so the strobe never re-rises in one step
  task send(input [7:0] code, input [15:0] data);
    begin
      @(negedge clk);
      cmdCode = code;
      cmdValid = 1'b1;
      cmdWrData = data;
      @(negedge clk);
      cmdValid = 1'b0;
    end
  endtask
  // Answer stands from the rising edge that samples the strobe, seen at the next falling edge
  task read(input [7:0] code, input [15:0] exp);
    begin
      send(code, 16'h0000);
      check(cmdRdValid === 1'b1 ? cmdRdData : 16'hdead, exp);
    end
  endtask
  task access(input [15:0] addr, input fetch);
    begin
      @(negedge clk);
      cpuAddr = addr;
      cpuAccess = 1'b1;
      cpuOpFetch = fetch;
      @(negedge clk);
      cpuAccess = 1'b0;
      cpuOpFetch = 1'b0;
    end
  endtask
  // Bounded wait; the request pulse stands only until the next rising edge,
  // so look a little after the falling edge once the model has updated
  task await_req(input tagMode);
    integer i;
    begin
      i = 0;
      @(negedge clk);
      #1;
      while (bkgndRequest !== 1'b1 && i < 20) begin
        @(negedge clk);
        #1;
        i = i + 1;
      end
      check({14'h0, bkgndRequest, tagExecBlock}, {14'h0, 1'b1, tagMode});
      if (i == 20)
        complete_run;
    end
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    read(8'he4, 16'h0000);
    read(8'he2, 16'hffff);
    $display("reset test done");
    send(8'hc4, 16'h00ff);
    read(8'he4, 16'h00b8);
    check({15'h0, commClockBus}, 16'h0001);
    send(8'hc2, 16'h1234);
    read(8'he2, 16'h1234);
    access(16'h1234, 1'b0);
    await_req(1'b0);
    read(8'he4, 16'h00f8);
    send(8'hc4, 16'h0008);
    read(8'he4, 16'h00c8);
    send(8'h08, 16'h0000);
    read(8'he4, 16'h0088);
    $display("forced test done");
    send(8'hc4, 16'h00a0);
    access(16'h1234, 1'b1);
    await_req(1'b1);
    read(8'he4, 16'h00e0);
    send(8'h08, 16'h0000);
    $display("tagged test done");
    send(8'hc4, 16'h0080);
    access(16'h1234, 1'b0);
    repeat (8) @(negedge clk);
    read(8'he4, 16'h0080);
    send(8'hc4, 16'h0000);
    send(8'h90, 16'h0000);
    read(8'he4, 16'h0000);
    send(8'hc4, 16'h0080);
    cpuWaitStop = 1'b1;
    memCmdFail = 1'b1;
    @(negedge clk);
    memCmdFail = 1'b0;
    read(8'he4, 16'h0086);
    send(8'h90, 16'h0000);
    read(8'he4, 16'h00c4);
    cpuWaitStop = 1'b0;
    send(8'h08, 16'h0000);
    read(8'he4, 16'h0080);
    $display("wait stop test done");
    complete_run;
  end
endmodule // tb_top
